/* File: dv/cpsr_mem_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Program and data memory behind the core
module cpsr_mem_model
  import cpsr_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Addresses from the core
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] gpr_addr,
  // Read data
  output logic [7:0] fetch_byte,
  output logic [7:0] gpr_byte
);
  // Unified 64 Kbyte space, no wrap or alias
  logic [7:0] mem [0:65535];
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'(i[7:0] ^ i[15:8]);
  end
  // Registered reads, like a synchronous array
  always_ff @(posedge core_clk)
  begin
    fetch_byte <= mem[fetch_addr];
    gpr_byte <= mem[gpr_addr];
  end
endmodule

/* File: dv/cpu_program_state_regs_tb.sv */
`timescale 1ns/1ps
module cpu_program_state_regs_tb
  import cpsr_pkg::*;
;
  // ==========================================================
  // Signals
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, irq_accept;
  logic [7:0] paddr, fetch_byte, gpr_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] probe_addr, gpr_addr, fetch_addr;
  logic [2:0] gpr_sel;
  logic er;
  cpsr_irq_t irq_in;
  cpsr_area_t probe_area;
  int n_errors = 0;
  int num_checks = 0;
  typedef struct packed
  {
    cpsr_op_t op;
    logic [7:0] a;
    logic [7:0] t;
    logic [7:0] res;
    logic [4:0] fl;
    logic shift;
  } cpsr_row_t;
  // Flags as h n z v c
  cpsr_row_t rows [8] = '{
    '{OP_ADD, 8'h0f, 8'h01, 8'h10, 5'h10, 1'b0},
    '{OP_ADD, 8'h80, 8'h80, 8'h00, 5'h07, 1'b0},
    '{OP_ADD, 8'h7f, 8'h01, 8'h80, 5'h1a, 1'b0},
    '{OP_SUB, 8'h10, 8'h01, 8'h0f, 5'h10, 1'b0},
    '{OP_SUB, 8'h00, 8'h01, 8'hff, 5'h19, 1'b0},
    '{OP_SUB, 8'h80, 8'h01, 8'h7f, 5'h12, 1'b0},
    '{OP_SHL, 8'h81, 8'h00, 8'h02, 5'h01, 1'b1},
    '{OP_SHR, 8'h01, 8'h00, 8'h00, 5'h05, 1'b1}};
  logic [15:0] probes [8] = '{16'h0000, 16'h007f, 16'h0080, 16'h7fff,
    16'h8000, 16'hffbf, 16'hffc0, 16'hffff};
  logic [31:0] fmask, fexp;

  cpsr_core dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_in(irq_in), .irq_accept(irq_accept), .probe_addr(probe_addr),
    .probe_area(probe_area), .gpr_sel(gpr_sel), .gpr_addr(gpr_addr),
    .fetch_addr(fetch_addr));
  cpsr_mem_model mem (.core_clk(core_clk), .fetch_addr(fetch_addr), .gpr_addr(gpr_addr),
    .fetch_byte(fetch_byte), .gpr_byte(gpr_byte));

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_errors++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait2();
    repeat (2) @(posedge core_clk);
  endtask

  task automatic reset_check();
    srst <= 1'b1;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    wait2();
    chk(fetch_addr, 32'h0000_fffd);
    chk(irq_accept, 32'h0000_0000);
    xfer(1'b0, OFS_PC, 32'h0);
    chk(rd, 32'h0000_fffd);
    chk(er, 32'h0000_0000);
    xfer(1'b0, OFS_PSW, 32'h0);
    chk(rd & 32'h0000_0070, 32'h0000_0030);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    irq_in = '0;
    probe_addr = 16'h0000;
    gpr_sel = 3'h0;
    reset_check();
    // Interrupts blocked after reset, even at the strongest level 0
    irq_in <= '{1'b1, 2'h0};
    wait2();
    chk(irq_accept, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      probe_addr <= probes[i];
      wait2();
      chk({30'h0, probe_area}, 32'(i / 2));
    end
    for (int i = 1; i < 6; i++)
    begin
      xfer(1'b1, 8'(i * 4), {16'hffff, 16'h1230 + 16'(i)});
      xfer(1'b0, 8'(i * 4), 32'h0);
      chk(rd, {16'h0000, 16'h1230 + 16'(i)});
    end
    // Rows: operands, command, then result and flags
    foreach (rows[i])
    begin
      xfer(1'b1, OFS_ACC, {24'h0, rows[i].a});
      xfer(1'b1, OFS_TMP, {24'h0, rows[i].t});
      xfer(1'b1, OFS_ALU, {30'h0, rows[i].op});
      xfer(1'b0, OFS_ALU, 32'h0);
      chk(rd & 32'h0000_0003, {30'h0, rows[i].op});
      xfer(1'b0, OFS_ACC, 32'h0);
      chk(rd & 32'h0000_00ff, {24'h0, rows[i].res});
      xfer(1'b0, OFS_PSW, 32'h0);
      fmask = rows[i].shift ? 32'h0000_000d : 32'h0000_008f;
      fexp = {24'h0, rows[i].fl[4], 3'h0, rows[i].fl[3:0]};
      chk(rd & fmask, fexp & fmask);
    end
    // Banks at both ends, registers at both ends
    for (int b = 0; b < 32; b += 31)
    begin
      xfer(1'b1, OFS_PSW, {16'h0, 5'(b), 3'h0, 8'h60});
      xfer(1'b0, OFS_PSW, 32'h0);
      chk(rd & 32'h0000_f870, {16'h0, 5'(b), 3'h0, 8'h60});
      for (int s = 0; s < 8; s += 7)
      begin
        gpr_sel <= 3'(s);
        wait2();
        chk(gpr_addr, 32'(16'h0100 + 16'(b * 8 + s)));
        @(posedge core_clk);
        chk(gpr_byte, 32'(8'(b * 8 + s) ^ 8'h01));
      end
    end
    // Enabled with mask level 10: only stronger levels pass
    for (int l = 0; l < 4; l++)
    begin
      irq_in <= '{1'b1, 2'(l)};
      wait2();
      chk(irq_accept, 32'(l < 2));
    end
    irq_in <= '{1'b0, 2'h0};
    wait2();
    chk(irq_accept, 32'h0000_0000);
    xfer(1'b1, OFS_PSW, 32'h0000_0020);
    irq_in <= '{1'b1, 2'h0};
    wait2();
    chk(irq_accept, 32'h0000_0000);
    // Unmapped place refuses and reads zero
    xfer(1'b1, 8'h20, 32'h0000_5a5a);
    chk(er, 32'h0000_0001);
    xfer(1'b0, 8'h20, 32'h0);
    chk(er, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    xfer(1'b1, OFS_PSW, 32'h0000_0070);
    xfer(1'b1, OFS_PC, 32'h0000_8000);
    wait2();
    chk(fetch_addr, 32'h0000_8000);
    @(posedge core_clk);
    chk(fetch_byte, 32'h0000_0080);
    chk(irq_accept, 32'h0000_0001);
    // Second reset in mid-run while an interrupt is being accepted
    reset_check();
    print_verdict();
  end
endmodule

/* File: hdl/cpsr_core.sv */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module cpsr_core
  import cpsr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt request
  input wire cpsr_irq_t irq_in,
  output logic irq_accept,
  // Memory map probe
  input wire logic [15:0] probe_addr,
  output cpsr_area_t probe_area,
  // Banked register address
  input wire logic [2:0] gpr_sel,
  output logic [15:0] gpr_addr,
  // Fetch address
  output logic [15:0] fetch_addr
);

  // ==========================================================
  // Register state
  logic [15:0] program_counter;
  logic [15:0] result_reg;
  logic [15:0] helper_word;
  logic [15:0] index_offset_reg;
  logic [15:0] extra_pointer;
  logic [15:0] stack_pointer;
  logic [7:0] bank_byte;
  logic [7:0] cond_flags;
  logic [1:0] last_op;
  logic bank_known;

  // ==========================================================
  // APB decode
  wire logic acc_phase = psel && penable;
  wire logic xfer_done = acc_phase && pready;
  wire logic wr_en = xfer_done && pwrite;
  wire logic hit_pc = (paddr == OFS_PC);
  wire logic hit_acc = (paddr == OFS_ACC);
  wire logic hit_tmp = (paddr == OFS_TMP);
  wire logic hit_idx = (paddr == OFS_IDX);
  wire logic hit_ext = (paddr == OFS_EXT);
  wire logic hit_stk = (paddr == OFS_STK);
  wire logic hit_psw = (paddr == OFS_PSW);
  wire logic hit_alu = (paddr == OFS_ALU);
  wire logic mapped = hit_pc || hit_acc || hit_tmp || hit_idx || hit_ext
                      || hit_stk || hit_psw || hit_alu;
  wire logic alu_fire = wr_en && hit_alu;
  wire cpsr_op_t alu_op = cpsr_op_t'(pwdata[1:0]);
  wire logic [15:0] processor_state_word = {bank_byte, cond_flags}; // RULE_07
  wire logic [4:0] bank_select = bank_byte[7:3]; // RULE_16
  wire logic [1:0] prio_mask_level = {cond_flags[CCR_IL1], cond_flags[CCR_IL0]};
  wire logic irq_ie = cond_flags[CCR_I];

  wire logic [31:0] next_prdata =
    hit_pc ? {16'h0000, program_counter} :
    hit_acc ? {16'h0000, result_reg} :
    hit_tmp ? {16'h0000, helper_word} :
    hit_idx ? {16'h0000, index_offset_reg} :
    hit_ext ? {16'h0000, extra_pointer} :
    hit_stk ? {16'h0000, stack_pointer} :
    hit_psw ? {16'h0000, processor_state_word} :
    hit_alu ? {30'h0, last_op} : 32'h00000000;

  // ==========================================================
  // Byte arithmetic on low bytes
  wire logic [7:0] alu_a = result_reg[7:0]; // RULE_05
  wire logic [7:0] alu_b = helper_word[7:0]; // RULE_05
  wire logic [8:0] add_full = {1'b0, alu_a} + {1'b0, alu_b};
  wire logic [8:0] sub_full = {1'b0, alu_a} - {1'b0, alu_b};
  wire logic [4:0] add_nib = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
  wire logic [4:0] sub_nib = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]};
  cpsr_alu_t alu_out;

  always_comb
  begin
    alu_out.res = add_full[7:0];
    alu_out.h = cond_flags[CCR_H];
    alu_out.v = cond_flags[CCR_V];
    alu_out.c = 1'b0;
    unique case (alu_op)
      OP_ADD:
      begin
        alu_out.res = add_full[7:0];
        alu_out.h = add_nib[4]; // RULE_09
        alu_out.v = (alu_a[7] == alu_b[7]) && (add_full[7] != alu_a[7]); // RULE_14
        alu_out.c = add_full[8]; // RULE_15
      end
      OP_SUB:
      begin
        alu_out.res = sub_full[7:0];
        alu_out.h = sub_nib[4]; // RULE_09
        alu_out.v = (alu_a[7] != alu_b[7]) && (sub_full[7] != alu_a[7]); // RULE_14
        alu_out.c = sub_full[8]; // RULE_15
      end
      OP_SHL:
      begin
        alu_out.res = {alu_a[6:0], 1'b0};
        alu_out.c = alu_a[7]; // RULE_15
      end
      OP_SHR:
      begin
        alu_out.res = {1'b0, alu_a[7:1]};
        alu_out.c = alu_a[0]; // RULE_15
      end
    endcase
    alu_out.n = alu_out.res[7]; // RULE_12
    alu_out.z = (alu_out.res == 8'h00); // RULE_13
  end

  // Shifts leave half-carry and overflow alone
  wire logic [7:0] next_flags_alu = {alu_out.h, cond_flags[CCR_I], cond_flags[CCR_IL1],
                                     cond_flags[CCR_IL0], alu_out.n, alu_out.z,
                                     alu_out.v, alu_out.c};

  // ==========================================================
  // Interrupt, memory map and bank address
  // Lower code is the higher level, so numeric less-than means higher priority
  wire logic next_irq_accept = irq_in.valid && irq_ie // RULE_10
                               && (irq_in.level < prio_mask_level); // RULE_11
  wire cpsr_area_t next_area =
    (probe_addr <= IO_LAST) ? AREA_IO : // RULE_02
    (probe_addr >= VECT_FIRST) ? AREA_VECT : // RULE_03
    (probe_addr >= PROG_FIRST) ? AREA_PROG : AREA_DATA; // RULE_01
  // Banks sit inside the data area well above the I/O registers
  wire logic [15:0] next_gpr_addr = BANK_BASE + {8'h00, bank_select, gpr_sel}; // RULE_17

  // ==========================================================
  // APB handshake: one wait state so read data comes from a flop
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= acc_phase && !pready;
      pslverr <= acc_phase && !pready && !mapped;
      if (acc_phase && !pready)
        prdata <= pwrite ? 32'h00000000 : next_prdata;
    end
  end

  // ==========================================================
  // Program counter
  always_ff @(posedge core_clk)
  begin
    if (srst)
      program_counter <= PC_RESET; // RULE_04
    else if (wr_en && hit_pc)
      program_counter <= pwdata[15:0]; // RULE_04
  end

  // ==========================================================
  // Bank byte has no reset, so its checks wait for a first write
  always_ff @(posedge core_clk)
  begin
    if (srst)
      bank_known <= 1'b0;
    else if (wr_en && hit_psw)
      bank_known <= 1'b1;
  end

  // ==========================================================
  // Data registers; no reset, their power-up value is undefined
  always_ff @(posedge core_clk)
  begin
    if (wr_en && hit_acc)
      result_reg <= pwdata[15:0];
    else if (alu_fire)
      result_reg <= {result_reg[15:8], alu_out.res}; // RULE_05
    if (wr_en && hit_tmp)
      helper_word <= pwdata[15:0];
    if (wr_en && hit_idx)
      index_offset_reg <= pwdata[15:0]; // RULE_06
    if (wr_en && hit_ext)
      extra_pointer <= pwdata[15:0]; // RULE_06
    if (wr_en && hit_stk)
      stack_pointer <= pwdata[15:0]; // RULE_06
    if (wr_en && hit_psw)
      bank_byte <= pwdata[15:8]; // RULE_07
    if (alu_fire)
      last_op <= alu_op;
  end

  // Condition flags in one process; only interrupt fields have a reset value
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cond_flags[CCR_I] <= 1'b0; // RULE_08
      cond_flags[CCR_IL1] <= IL_RESET[1]; // RULE_08
      cond_flags[CCR_IL0] <= IL_RESET[0]; // RULE_08
    end
    else if (wr_en && hit_psw)
    begin
      cond_flags[CCR_I] <= pwdata[CCR_I];
      cond_flags[CCR_IL1] <= pwdata[CCR_IL1];
      cond_flags[CCR_IL0] <= pwdata[CCR_IL0];
    end
    if (alu_fire)
    begin
      cond_flags[CCR_H] <= next_flags_alu[CCR_H];
      cond_flags[CCR_N] <= next_flags_alu[CCR_N];
      cond_flags[CCR_Z] <= next_flags_alu[CCR_Z];
      cond_flags[CCR_V] <= next_flags_alu[CCR_V];
      cond_flags[CCR_C] <= next_flags_alu[CCR_C];
    end
    else if (wr_en && hit_psw)
    begin
      cond_flags[CCR_H] <= pwdata[CCR_H];
      cond_flags[CCR_N] <= pwdata[CCR_N];
      cond_flags[CCR_Z] <= pwdata[CCR_Z];
      cond_flags[CCR_V] <= pwdata[CCR_V];
      cond_flags[CCR_C] <= pwdata[CCR_C];
    end
  end

  // ==========================================================
  // Side outputs
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      irq_accept <= 1'b0;
      probe_area <= AREA_IO;
      gpr_addr <= BANK_BASE;
      fetch_addr <= PC_RESET;
    end
    else
    begin
      irq_accept <= next_irq_accept; // RULE_10
      probe_area <= next_area; // RULE_03
      gpr_addr <= next_gpr_addr; // RULE_16
      fetch_addr <= program_counter; // RULE_04
    end
  end

  // ==========================================================
  // Checks
  property p_reset_state;
    @(posedge core_clk) disable iff (srst)
      $fell(srst) |-> (program_counter == PC_RESET) && !irq_ie
                      && (prio_mask_level == IL_RESET);
  endproperty
  a_reset_state: assert property (p_reset_state) // RULE_08
    else $error("reset state of pc or interrupt fields wrong");

  property p_fetch_follows_pc;
    @(posedge core_clk) disable iff (srst)
      (wr_en && hit_pc) |=> ##1 (fetch_addr == $past(pwdata[15:0], 2));
  endproperty
  a_fetch_follows_pc: assert property (p_fetch_follows_pc) // RULE_04
    else $error("fetch address does not follow pc write");

  property p_irq_blocked;
    @(posedge core_clk) disable iff (srst)
      !irq_ie |=> !irq_accept;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) // RULE_10
    else $error("interrupt accepted while disabled");

  property p_irq_level;
    @(posedge core_clk) disable iff (srst)
      (irq_in.valid && irq_ie) |=>
        (irq_accept == ($past(irq_in.level) < $past(prio_mask_level)));
  endproperty
  a_irq_level: assert property (p_irq_level) // RULE_11
    else $error("interrupt level compare wrong");

  property p_add_carry;
    @(posedge core_clk) disable iff (srst)
      (alu_fire && alu_op == OP_ADD) |=>
        (cond_flags[CCR_C] == (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}) > 9'h0ff));
  endproperty
  a_add_carry: assert property (p_add_carry) // RULE_15
    else $error("add carry flag wrong");

  property p_half_carry;
    @(posedge core_clk) disable iff (srst)
      (alu_fire && alu_op == OP_ADD) |=>
        (cond_flags[CCR_H] == (({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])}) > 5'h0f));
  endproperty
  a_half_carry: assert property (p_half_carry) // RULE_09
    else $error("half carry flag wrong");

  property p_zero_neg;
    @(posedge core_clk) disable iff (srst)
      alu_fire |=> (cond_flags[CCR_Z] == (result_reg[7:0] == 8'h00))
                   && (cond_flags[CCR_N] == result_reg[7]);
  endproperty
  a_zero_neg: assert property (p_zero_neg) // RULE_13
    else $error("zero or negative flag disagrees with result");

  property p_shift_carry;
    @(posedge core_clk) disable iff (srst)
      (alu_fire && alu_op == OP_SHR) |=> (cond_flags[CCR_C] == $past(alu_a[0]))
                                         && (result_reg[7] == 1'b0);
  endproperty
  a_shift_carry: assert property (p_shift_carry) // RULE_15
    else $error("shift carry wrong");

  property p_bank_addr;
    @(posedge core_clk) disable iff (srst)
      bank_known |=> (gpr_addr == BANK_BASE + {8'h00, $past(bank_select), $past(gpr_sel)});
  endproperty
  a_bank_addr: assert property (p_bank_addr) // RULE_17
    else $error("banked register address wrong");

  property p_area_io;
    @(posedge core_clk) disable iff (srst)
      (probe_addr <= IO_LAST) |=> (probe_area == AREA_IO);
  endproperty
  a_area_io: assert property (p_area_io) // RULE_02
    else $error("low address not in io area");

  property p_apb_wait;
    @(posedge core_clk) disable iff (srst)
      (acc_phase && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb ready timing wrong");

  property p_err_with_ready;
    @(posedge core_clk) disable iff (srst)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error response without ready");

  property p_area_data;
    @(posedge core_clk) disable iff (srst)
      (probe_addr > IO_LAST) && (probe_addr < PROG_FIRST) |=> (probe_area == AREA_DATA);
  endproperty
  a_area_data: assert property (p_area_data) // RULE_01
    else $error("middle address not in data area");

  property p_area_top;
    @(posedge core_clk) disable iff (srst)
      (probe_addr >= VECT_FIRST) |=> (probe_area == AREA_VECT);
  endproperty
  a_area_top: assert property (p_area_top) // RULE_03
    else $error("top address not in vector tables");

  property p_sub_borrow;
    @(posedge core_clk) disable iff (srst)
      (alu_fire && alu_op == OP_SUB) |=> (cond_flags[CCR_C] == ($past(alu_a) < $past(alu_b)));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) // RULE_15
    else $error("subtract borrow flag wrong");

  property p_add_overflow;
    @(posedge core_clk) disable iff (srst)
      (alu_fire && alu_op == OP_ADD) |=>
        (cond_flags[CCR_V] == (($signed($past(alu_a)) + $signed($past(alu_b)) > 127)
                               || ($signed($past(alu_a)) + $signed($past(alu_b)) < -128)));
  endproperty
  a_add_overflow: assert property (p_add_overflow) // RULE_14
    else $error("add overflow flag wrong");

  property p_gpr_in_data;
    @(posedge core_clk) disable iff (srst)
      bank_known |=> (gpr_addr > IO_LAST) && (gpr_addr < PROG_FIRST);
  endproperty
  a_gpr_in_data: assert property (p_gpr_in_data) // RULE_17
    else $error("banked register outside data area");

endmodule

/* File: inc/cpsr_pkg.sv */
// Functional notes
// RULE_01: One unified 64 Kbyte space holds I/O, data and program areas.
// RULE_02: I/O area starts at address zero; data area lies directly above.
// RULE_03: Program area is at the top; vector tables at its highest addresses.
// RULE_04: Program counter is 16 bits and loads fffd on reset.
// RULE_05: Accumulator and temporary accumulator are 16 bits; byte ops use low byte.
// RULE_06: Index, extra pointer and stack pointer are each 16 bits wide.
// RULE_07: Status word: bank select in upper byte, condition flags in lower byte.
// RULE_08: Reset clears interrupt enable, sets level mask to 11; rest undefined.
// RULE_09: Half-carry set on carry or borrow from bit 3 into bit 4.
// RULE_10: Interrupts accepted only while interrupt enable is 1.
// RULE_11: Interrupt serviced only if its level beats the two-bit mask field.
// RULE_12: Negative flag follows the result's most significant bit.
// RULE_13: Zero flag set when the result equals zero.
// RULE_14: Overflow flag set on two's-complement overflow, else cleared; here shifts leave it unchanged.
// RULE_15: Carry set on carry or borrow out of bit 7; shifts load shifted-out bit.
// RULE_16: Banks of eight 8-bit registers, up to 32 banks, chosen by bank select.
// RULE_17: Banked register address is a fixed map of bank and number into data area.
package cpsr_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_PC = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_TMP = 8'h08;
  localparam logic [7:0] OFS_IDX = 8'h0c;
  localparam logic [7:0] OFS_EXT = 8'h10;
  localparam logic [7:0] OFS_STK = 8'h14;
  localparam logic [7:0] OFS_PSW = 8'h18;
  localparam logic [7:0] OFS_ALU = 8'h1c;

  // ==========================================================
  // Reset values and status word layout
  localparam logic [15:0] PC_RESET = 16'hfffd;
  localparam logic [1:0] IL_RESET = 2'h3;
  localparam int PSW_BANK_LSB = 11;
  localparam int CCR_H = 7;
  localparam int CCR_I = 6;
  localparam int CCR_IL1 = 5;
  localparam int CCR_IL0 = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;

  // ==========================================================
  // Memory map
  localparam logic [15:0] IO_LAST = 16'h007f;
  localparam logic [15:0] PROG_FIRST = 16'h8000;
  localparam logic [15:0] VECT_FIRST = 16'hffc0;
  localparam logic [15:0] BANK_BASE = 16'h0100;
  localparam int BANK_REGS = 8;
  localparam int BANK_COUNT = 32;

  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    OP_ADD = 2'b00,
    OP_SUB = 2'b01,
    OP_SHL = 2'b10,
    OP_SHR = 2'b11
  } cpsr_op_t;

  typedef enum logic [1:0]
  {
    AREA_IO = 2'b00,
    AREA_DATA = 2'b01,
    AREA_PROG = 2'b10,
    AREA_VECT = 2'b11
  } cpsr_area_t;

  typedef struct packed
  {
    logic [7:0] res;
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } cpsr_alu_t;

  typedef struct packed
  {
    logic valid;
    logic [1:0] level;
  } cpsr_irq_t;

endpackage
